// file: rtl/tmr_pkg.sv
package tmr_pkg;

  // ----------------------------------------
  // Register indices (byte address = 4*idx)
  // ----------------------------------------
  localparam logic [5:0] IDX_SECT_CTRL  = 6'h0E;
  localparam logic [5:0] IDX_TZ_CTRL    = 6'h0F;
  localparam logic [5:0] IDX_RELOAD_HI  = 6'h10;
  localparam logic [5:0] IDX_RELOAD_LO  = 6'h11;
  localparam logic [5:0] IDX_COUNT_HI   = 6'h12;
  localparam logic [5:0] IDX_COUNT_LO   = 6'h13;
  localparam logic [5:0] IDX_IRQ_STAT   = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK   = 6'h21;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int         RUN_LSB        = 4;
  localparam int         TZ_RUN_BIT     = 4;
  localparam int         ST_UFL_BIT     = 0;
  localparam int         ST_RXSTOP_BIT  = 1;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [1:0] RST_IRQ        = 2'h0;

  // ----------------------------------------
  // Rates and core clock: FAST_KHZ and CORE_KHZ in kHz, SLOW_HZ and CORE_HZ in Hz
  // ----------------------------------------
  localparam int CORE_KHZ  = 20000;
  localparam int FAST_KHZ  = 13560;
  localparam int SLOW_HZ   = 211875;
  localparam int CORE_HZ   = CORE_KHZ * 1000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    START_NONE,
    START_TX_END,
    START_LFO_NOUFL,
    START_LFO_UFL
  } tmr_start_t;

  typedef enum logic [1:0] {
    CLK_FAST,
    CLK_SLOW,
    CLK_CASC_TWO,
    CLK_CASC_ONE
  } tmr_clk_t;

  typedef struct packed {
    logic       halt_on_receive;
    logic       rsvd6;
    tmr_start_t start_mode_select;
    logic       auto_reload_enable;
    logic       rsvd2;
    tmr_clk_t   count_clock_select;
  } tmr_zctrl_t;

  typedef struct packed {
    logic tx_end;
    logic rx_four_bits;
    logic lfo_level;
    logic casc_one;
    logic casc_two;
  } tmr_events_t;

endpackage

// file: rtl/tmr_rate_gen.sv
`timescale 1ns/10ps

// Fractional divider: one-cycle enable at RATE out of BASE.
module tmr_rate_gen
  import tmr_pkg::*;
#(
  parameter int RATE = FAST_KHZ,
  parameter int BASE = CORE_KHZ
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  output logic      tick_out
);

  logic [31:0] acc_reg;
  logic [32:0] acc_sum;

  // Sum of the accumulator and the rate step.
  assign acc_sum = {1'b0, acc_reg} + 33'(RATE);

  // ----------------------------------------
  // Phase accumulator
  // ----------------------------------------
  // The accumulator wraps at BASE and pulses on each wrap.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_reg  <= 32'h0000_0000;
      tick_out <= 1'b0;
    end else if (acc_sum >= 33'(BASE)) begin
      acc_reg  <= 32'(acc_sum - 33'(BASE));
      tick_out <= 1'b1;
    end else begin
      acc_reg  <= acc_sum[31:0];
      tick_out <= 1'b0;
    end
  end

endmodule

// file: rtl/tmr_section.sv
`timescale 1ns/10ps

module tmr_section
  import tmr_pkg::*;
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire tmr_events_t EVENTS_IN,
  output logic      [3:0]  TIMER_ACTIVE_OUT,
  output logic             TZ_UNDERFLOW_OUT,
  output logic             IRQ_OUT
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  typedef enum logic {ST_IDLE, ST_RUN} tmr_state_t;

  logic [1:0]  rst_sync_reg;
  logic        rst_n;
  tmr_state_t  state_reg;
  logic [3:1]  other_active_reg;
  tmr_zctrl_t  zctrl_reg;
  logic [7:0]  reload_hi_reg;
  logic [7:0]  reload_lo_reg;
  logic [15:0] count_reg;
  logic [1:0]  stat_reg;
  logic [1:0]  mask_reg;
  logic        lfo_prev_reg;
  logic        fast_tick;
  logic        slow_tick;
  logic        count_tick;
  logic        wr_en;
  logic        rd_en;
  logic [5:0]  idx;
  logic        mapped;
  logic [7:0]  wbyte;
  logic        sw_change;
  logic        sw_start;
  logic        sw_stop;
  logic        lfo_mode;
  logic        lfo_edge;
  logic        hw_start;
  logic        hw_stop;
  logic        rx_stop;
  logic        underflow;
  logic        at_zero;
  logic [15:0] timer_zero_reload_value;
  logic [7:0]  rd_byte;
  logic [1:0]  stat_next;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Two flops release the asynchronous reset cleanly.
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Count clock enables
  // ----------------------------------------
  // Fast rate enable.
  tmr_rate_gen #(
    .RATE (FAST_KHZ),
    .BASE (CORE_KHZ)
  ) u_fast_rate (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (rst_n),
    .tick_out (fast_tick)
  );

  // Slow rate enable.
  tmr_rate_gen #(
    .RATE (SLOW_HZ),
    .BASE (CORE_HZ)
  ) u_slow_rate (
    .clk_in   (CORE_CLK_IN),
    .rst_n_in (rst_n),
    .tick_out (slow_tick)
  );

  // Select the decrement enable for timer zero.
  always_comb begin
    unique case (zctrl_reg.count_clock_select)
      CLK_FAST:     count_tick = fast_tick;
      CLK_SLOW:     count_tick = slow_tick;
      CLK_CASC_TWO: count_tick = EVENTS_IN.casc_two;
      CLK_CASC_ONE: count_tick = EVENTS_IN.casc_one;
    endcase
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Writes take effect in the access phase; reads are fetched at setup.
  assign wr_en  = PSEL_IN && PENABLE_IN && PWRITE_IN && mapped;
  assign rd_en  = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign idx    = PADDR_IN[7:2];
  assign wbyte  = PWDATA_IN[7:0];
  assign mapped = (PADDR_IN[1:0] == 2'h0) &&
                  (idx == IDX_SECT_CTRL || idx == IDX_TZ_CTRL ||
                   idx == IDX_RELOAD_HI || idx == IDX_RELOAD_LO ||
                   idx == IDX_COUNT_HI  || idx == IDX_COUNT_LO ||
                   idx == IDX_IRQ_STAT  || idx == IDX_IRQ_MASK);

  // Control write for timer zero, gated by its mask bit.
  assign sw_change = wr_en && (idx == IDX_SECT_CTRL) &&
                     wbyte[TZ_RUN_BIT - RUN_LSB];
  assign sw_start  = sw_change && wbyte[TZ_RUN_BIT];
  assign sw_stop   = sw_change && !wbyte[TZ_RUN_BIT];

  // ----------------------------------------
  // Timer zero events
  // ----------------------------------------
  assign lfo_mode = zctrl_reg.start_mode_select[1];
  assign lfo_edge = lfo_mode && EVENTS_IN.lfo_level && !lfo_prev_reg;
  assign timer_zero_reload_value = {reload_hi_reg, reload_lo_reg};
  assign at_zero = (count_reg == 16'h0000);

  // Hardware start: transmission end, or trimming edge while idle.
  assign hw_start = ((zctrl_reg.start_mode_select == START_TX_END) &&
                     EVENTS_IN.tx_end) ||
                    (lfo_edge && state_reg == ST_IDLE);

  // Stop on the receive event only outside trimming modes.
  assign rx_stop = zctrl_reg.halt_on_receive && !lfo_mode &&
                   EVENTS_IN.rx_four_bits &&
                   state_reg == ST_RUN;

  // Trimming mode: a second edge ends the measurement.
  assign hw_stop = rx_stop || (lfo_edge && state_reg == ST_RUN);

  // Underflow is a tick at zero, except in trimming without underflow.
  assign underflow = (state_reg == ST_RUN) && count_tick && at_zero &&
                     (zctrl_reg.start_mode_select != START_LFO_NOUFL);

  // Edge detector for the oscillator input.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      lfo_prev_reg <= 1'b0;
    end else begin
      lfo_prev_reg <= EVENTS_IN.lfo_level;
    end
  end

  // ----------------------------------------
  // Timer zero state
  // ----------------------------------------
  // Software has priority, then hardware start, stop, underflow.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (sw_start || (!sw_stop && hw_start)) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (sw_stop) begin
            state_reg <= ST_IDLE;
          end else if (sw_start || hw_start) begin
            state_reg <= ST_RUN;
          end else if (hw_stop) begin
            state_reg <= ST_IDLE;
          end else if (underflow && !zctrl_reg.auto_reload_enable) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Timer zero counter
  // ----------------------------------------
  // Loads at every start event, decrements on the selected enable.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
    end else if (sw_start || (!sw_stop && hw_start)) begin
      count_reg <= timer_zero_reload_value;
    end else if (state_reg == ST_RUN && !sw_stop && !hw_stop && count_tick) begin
      if (underflow && zctrl_reg.auto_reload_enable) begin
        count_reg <= timer_zero_reload_value;
      end else if (!at_zero) begin
        count_reg <= count_reg - 16'h0001;
      end
    end
  end

  // Underflow pulse for cascading.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      TZ_UNDERFLOW_OUT <= 1'b0;
    end else begin
      TZ_UNDERFLOW_OUT <= underflow && !sw_change && !hw_stop;
    end
  end

  // ----------------------------------------
  // Other timers' running bits
  // ----------------------------------------
  // Each bit changes only when its own mask bit is written as one.
  generate
    for (genvar n = 1; n < 4; n++) begin : g_other
      always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
          other_active_reg[n] <= 1'b0;
        end else if (wr_en && idx == IDX_SECT_CTRL && wbyte[n]) begin
          other_active_reg[n] <= wbyte[n + RUN_LSB];
        end
      end
    end
  endgenerate

  // Running state seen by software and by the other timers.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      TIMER_ACTIVE_OUT <= 4'h0;
    end else begin
      TIMER_ACTIVE_OUT <= {other_active_reg, state_reg == ST_RUN};
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Control and reload bytes; reload writes never touch the count.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      zctrl_reg     <= tmr_zctrl_t'(RST_BYTE);
      reload_hi_reg <= RST_BYTE;
      reload_lo_reg <= RST_BYTE;
      mask_reg      <= RST_IRQ;
    end else if (wr_en) begin
      if (idx == IDX_TZ_CTRL) begin
        zctrl_reg       <= tmr_zctrl_t'(wbyte);
        zctrl_reg.rsvd6 <= 1'b0;
        zctrl_reg.rsvd2 <= 1'b0;
      end
      if (idx == IDX_RELOAD_HI) begin
        reload_hi_reg <= wbyte;
      end
      if (idx == IDX_RELOAD_LO) begin
        reload_lo_reg <= wbyte;
      end
      if (idx == IDX_IRQ_MASK) begin
        mask_reg <= wbyte[1:0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  // Write one to clear; a new event in the same cycle wins.
  always_comb begin
    stat_next = stat_reg;
    if (wr_en && idx == IDX_IRQ_STAT) begin
      stat_next = stat_reg & ~wbyte[1:0];
    end
    if (TZ_UNDERFLOW_OUT) begin
      stat_next[ST_UFL_BIT] = 1'b1;
    end
    if (rx_stop && !sw_change) begin
      stat_next[ST_RXSTOP_BIT] = 1'b1;
    end
  end

  // Sticky flags and the level interrupt.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= RST_IRQ;
      IRQ_OUT  <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      IRQ_OUT  <= |(stat_next & mask_reg);
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read byte selected by the register index.
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_SECT_CTRL: rd_byte = {other_active_reg[3], other_active_reg[2],
                                other_active_reg[1], state_reg == ST_RUN,
                                4'h0};
      IDX_TZ_CTRL:   rd_byte = zctrl_reg;
      IDX_RELOAD_HI: rd_byte = reload_hi_reg;
      IDX_RELOAD_LO: rd_byte = reload_lo_reg;
      IDX_COUNT_HI:  rd_byte = count_reg[15:8];
      IDX_COUNT_LO:  rd_byte = count_reg[7:0];
      IDX_IRQ_STAT:  rd_byte = {6'h00, stat_reg};
      IDX_IRQ_MASK:  rd_byte = {6'h00, mask_reg};
      default:       rd_byte = 8'h00;
    endcase
  end

  // Read data is captured at setup and stands through the access.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (rd_en) begin
      PRDATA_OUT <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Zero-wait answer; unmapped addresses report an error.
  always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT  <= 1'b1;
      PSLVERR_OUT <= PSEL_IN && !PENABLE_IN && !mapped;
    end
  end

endmodule

// file: verification/test_timer_section_with_timer_zero.sv
`timescale 1ns/10ps

module test_timer_section_with_timer_zero;
  import tmr_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic        rdy;
  logic        err;
  logic        irq;
  logic        ufl;
  logic        e;
  logic [7:0]  paddr;
  logic [7:0]  q;
  logic [7:0]  d;
  logic [3:0]  run;
  logic [3:0]  act;
  logic [31:0] pwd;
  logic [31:0] prd;
  tmr_events_t ev;
  int          n_mismatch;
  int          cmp_count;
  int          cyc = 0;
  int          n_ufl = 0;
  int          n0;
  longint      x;
  logic [5:0]  ix[8] = '{IDX_SECT_CTRL, IDX_TZ_CTRL, IDX_RELOAD_HI, IDX_RELOAD_LO,
                         IDX_COUNT_HI, IDX_COUNT_LO, IDX_IRQ_STAT, IDX_IRQ_MASK};
  logic [7:0]  cv[4] = '{8'hFF, 8'hF0, 8'h0F, 8'hF0};

  tmr_section uut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy),
    .PSLVERR_OUT(err), .EVENTS_IN(ev), .TIMER_ACTIVE_OUT(act), .TZ_UNDERFLOW_OUT(ufl), .IRQ_OUT(irq));

  // ----------------------------------------
  // Clock, underflow counter and timeout
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Counts underflow pulses and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (ufl === 1'b1) n_ufl++;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] xp, input logic [7:0] g);
    cmp_count++;
    if (g !== xp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, xp, g);
    end
  endtask

  // One APB transfer; ready, read data and error are taken at the rising edge that ends the access.
  task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] dt);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {i, 2'h0};
    pwd <= {24'h0, dt};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = prd[7:0];
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [5:0] i, input logic [7:0] xp);
    apb(1'b0, i, 8'h00);
    chk(nm, xp, q);
  endtask

  // Single-cycle event pulse on one bit of the event bundle.
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
  endtask

  task automatic wait_ufl();
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (ufl !== 1'b1 && k < 5000);
    chk("underflow", 8'h01, {7'h0, ufl});
    @(posedge clk);
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_n, psel, pen, pwr, paddr, pwd, ev} = '0;
    n_mismatch = 0;
    cmp_count = 0;
    void'($urandom(81));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (ix[j]) rd("reset value", ix[j], 8'h00);
    apb(1'b0, 6'h05, 8'h00);
    chk("unmapped error", 8'h01, {7'h0, e});
    wr_only: begin
      apb(1'b1, IDX_COUNT_HI, 8'h77);
      rd("count high", IDX_COUNT_HI, 8'h00);
    end
    repeat (4) begin
      d = 8'($urandom);
      apb(1'b1, IDX_TZ_CTRL, d);
      rd("timer control", IDX_TZ_CTRL, d & 8'hBB);
      apb(1'b1, IDX_RELOAD_HI, ~d);
      rd("reload high", IDX_RELOAD_HI, ~d);
    end
    $display("test registers done");
    // Slow clock and a 0xFF00 reload keep timer zero running through the mask test.
    apb(1'b1, IDX_TZ_CTRL, 8'h01);
    apb(1'b1, IDX_RELOAD_HI, 8'hFF);
    run = 4'h0;
    for (int j = 0; j < 16; j++) begin
      d = (j < 4) ? cv[j] : 8'($urandom);
      apb(1'b1, IDX_SECT_CTRL, d);
      run = (run & ~d[3:0]) | (d[7:4] & d[3:0]);
      rd("running", IDX_SECT_CTRL, {run, 4'h0});
      chk("active port", {4'h0, run}, {4'h0, act});
    end
    $display("test masked write done");
    // Cascade clocking freezes the count unless the chosen underflow pulses.
    apb(1'b1, IDX_TZ_CTRL, 8'h02);
    apb(1'b1, IDX_RELOAD_HI, 8'h12);
    apb(1'b1, IDX_RELOAD_LO, 8'h34);
    apb(1'b1, IDX_SECT_CTRL, 8'h1F);
    rd("count high", IDX_COUNT_HI, 8'h12);
    rd("count low", IDX_COUNT_LO, 8'h34);
    apb(1'b1, IDX_RELOAD_HI, 8'h56);
    repeat (3) pulse(0);
    pulse(1);
    rd("count low", IDX_COUNT_LO, 8'h31);
    rd("count high", IDX_COUNT_HI, 8'h12);
    apb(1'b1, IDX_TZ_CTRL, 8'h03);
    pulse(1);
    pulse(0);
    rd("count low", IDX_COUNT_LO, 8'h30);
    apb(1'b1, IDX_SECT_CTRL, 8'h11);
    rd("count high", IDX_COUNT_HI, 8'h56);
    $display("test reload done");
    apb(1'b1, IDX_SECT_CTRL, 8'h0F);
    apb(1'b1, IDX_IRQ_MASK, 8'h01);
    apb(1'b1, IDX_RELOAD_HI, 8'h00);
    apb(1'b1, IDX_RELOAD_LO, 8'h05);
    apb(1'b1, IDX_TZ_CTRL, 8'h00);
    pulse(4);
    rd("no auto start", IDX_SECT_CTRL, 8'h00);
    apb(1'b1, IDX_TZ_CTRL, 8'h10);
    pulse(4);
    wait_ufl();
    repeat (3) @(posedge clk);
    chk("irq", 8'h01, {7'h0, irq});
    rd("stopped", IDX_SECT_CTRL, 8'h00);
    rd("status", IDX_IRQ_STAT, 8'h01);
    apb(1'b1, IDX_IRQ_STAT, 8'h01);
    repeat (3) @(posedge clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    apb(1'b1, IDX_TZ_CTRL, 8'h18);
    pulse(4);
    wait_ufl();
    wait_ufl();
    rd("auto reload", IDX_SECT_CTRL, 8'h10);
    $display("test underflow done");
    apb(1'b1, IDX_TZ_CTRL, 8'h91);
    pulse(4);
    apb(1'b1, IDX_IRQ_STAT, 8'h03);
    pulse(3);
    rd("halt on receive", IDX_SECT_CTRL, 8'h00);
    rd("status", IDX_IRQ_STAT, 8'h02);
    apb(1'b1, IDX_TZ_CTRL, 8'h11);
    pulse(4);
    pulse(3);
    rd("no halt", IDX_SECT_CTRL, 8'h10);
    // Stop timer zero so that the first oscillator edge starts it instead of ending it.
    apb(1'b1, IDX_SECT_CTRL, 8'h01);
    apb(1'b1, IDX_TZ_CTRL, 8'hA0);
    pulse(2);
    pulse(3);
    rd("trim running", IDX_SECT_CTRL, 8'h10);
    n0 = n_ufl;
    repeat (40) @(posedge clk);
    rd("trim count", IDX_COUNT_LO, 8'h00);
    chk("trim no underflow", 8'h00, 8'(n_ufl - n0));
    pulse(2);
    rd("trim stopped", IDX_SECT_CTRL, 8'h00);
    apb(1'b1, IDX_TZ_CTRL, 8'hB0);
    pulse(2);
    wait_ufl();
    $display("test modes done");
    apb(1'b1, IDX_RELOAD_LO, 8'h00);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, IDX_TZ_CTRL, 8'h08 | 8'(j));
      apb(1'b1, IDX_SECT_CTRL, 8'h11);
      n0 = n_ufl;
      repeat (j ? 20000 : 2000) @(posedge clk);
      x = (j ? 20000 * longint'(SLOW_HZ) : 2000 * longint'(FAST_KHZ) * 1000) / CORE_HZ;
      chk("tick rate", 8'h01, {7'h0, (n_ufl - n0 >= x - 2) && (n_ufl - n0 <= x + 2)});
    end
    $display("test rates done");
    finish_test();
  end
endmodule

// file: verification/tmr_section_assertions.sv
`timescale 1ns/10ps

// ----------------------------------------
// Bus and control-write checker
// ----------------------------------------
module tmr_section_chk
  import tmr_pkg::*;
(
  input wire logic        CORE_CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic [3:0]  TIMER_ACTIVE_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic acc;
  logic ctl;

  // Access phase and section control address decode.
  assign acc = PSEL_IN && PENABLE_IN;
  assign ctl = PADDR_IN == {IDX_SECT_CTRL, 2'h0};

  a_ready_setup: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
    else $error("ready missing after setup");
  a_ready_access: assert property (acc |-> PREADY_OUT)
    else $error("ready low in access");
  a_err_only_acc: assert property (PSLVERR_OUT |-> acc)
    else $error("error outside access");
  a_err_misalign: assert property (acc && PADDR_IN[1:0] != 2'h0 |-> PSLVERR_OUT)
    else $error("misaligned access not refused");
  a_err_mapped: assert property (acc && ctl |-> !PSLVERR_OUT)
    else $error("mapped access refused");
  a_rdata_upper: assert property (acc && !PWRITE_IN |-> PRDATA_OUT[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_run_read: assert property (acc && !PWRITE_IN && ctl |->
    PRDATA_OUT[7:0] == {TIMER_ACTIVE_OUT, 4'h0})
    else $error("control read differs from running state");
  a_mask_keeps: assert property (acc && PWRITE_IN && ctl |-> ##2
    ((TIMER_ACTIVE_OUT[3:1] ^ $past(TIMER_ACTIVE_OUT[3:1], 2)) & ~$past(PWDATA_IN[3:1], 2)) == 3'h0)
    else $error("unmasked running bit changed");
  a_mask_sets: assert property (acc && PWRITE_IN && ctl |-> ##2
    (TIMER_ACTIVE_OUT[3:1] & $past(PWDATA_IN[3:1], 2)) == ($past(PWDATA_IN[7:5], 2) & $past(PWDATA_IN[3:1], 2)))
    else $error("masked running bit not written");
endmodule

bind tmr_section tmr_section_chk u_chk (.CORE_CLK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
  .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .TIMER_ACTIVE_OUT);
